//--- logic/ssprb_pkg.sv
// Package of the sensor serial port: register map, command codes, reset values.
// Assumes a core clock at 250 MHz and a serial clock from the host.
package ssprb_pkg;
   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [6:0] ADDR_MOVEMENT_STATUS = 7'h02;
   localparam logic [6:0] ADDR_Y_DISPLACEMENT  = 7'h03;
   localparam logic [6:0] ADDR_X_DISPLACEMENT  = 7'h04;
   localparam logic [6:0] ADDR_SURFACE_QUALITY = 7'h05;
   localparam logic [6:0] ADDR_EXPOSURE_HI     = 7'h06;
   localparam logic [6:0] ADDR_EXPOSURE_LO     = 7'h07;
   localparam logic [6:0] ADDR_PEAK_PIXEL      = 7'h08;
   localparam logic [6:0] ADDR_CONFIG_BITS     = 7'h11;
   localparam logic [6:0] ADDR_RESET_COMMAND   = 7'h3a;
   localparam logic [6:0] ADDR_BURST_READOUT   = 7'h42;
   // ------------------------------------------------------------
   // Values and fields
   // ------------------------------------------------------------
   localparam logic [7:0] RESET_KEY            = 8'h5a;
   localparam logic [7:0] CONFIG_BITS_RESET    = 8'h03;
   localparam int         CONFIG_REST_BIT      = 5;
   localparam int         STATUS_MOT_BIT       = 7;
   localparam int         STATUS_OVF_BIT       = 4;
   localparam int         DIR_BIT              = 7;
   localparam int         BURST_LEN            = 7;
   localparam int         BYTE_BITS            = 8;
   // Number of entries in the register storage array
   localparam int         REG_DEPTH            = 128;
endpackage

//--- logic/ssprb_xfer_if.sv
// Interface carrying register requests from the serial logic to the core.
// Assumes request fields are stable while their toggle crosses domains.
`timescale 1ns/100ps
interface ssprb_xfer_if;
   logic       req_tgl;
   logic       req_wr;
   logic [6:0] req_addr;
   logic [7:0] req_data;
   modport link (output req_tgl, output req_wr, output req_addr, output req_data);
   modport core (input  req_tgl, input  req_wr, input  req_addr, input  req_data);
endinterface

//--- logic/ssprb_regmem.sv
// Small register memory with registered read port.
// Assumes one write and one read per core clock.
`timescale 1ns/100ps
module ssprb_regmem #(
   parameter int DEPTH = 128,
   parameter int AW    = 7
) (
   input  wire logic          clk_i,
   input  wire logic          we_i,
   input  wire logic [AW-1:0] waddr_i,
   input  wire logic [7:0]    wdata_i,
   input  wire logic [AW-1:0] raddr_i,
   output logic      [7:0]    rdata_o
);
   logic [7:0] mem [DEPTH];
   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
   end
endmodule

//--- logic/ssprb_top.sv
// Serial slave port of a motion sensor: read, write, burst, reset and shutdown.
// Assumes the host owns the serial clock and keeps the command gaps.
// Notes on behaviour
// - Read: address byte top zero, then data
// - Output on falling edge, sample rising
// - Output bit held to next falling edge
// - Burst register read enters burst mode
// - Burst sends seven motion bytes in order
// - Select high ends burst early
// - Burst data captured at last address bit
// - No transaction after burst until deselect
// - Inputs ignored while deselected before reset
// - Configuration bit selects forced rest
// - Light source low current in shutdown
// - Write: address top one, then data
// - Deselect aborts transaction, output released
`timescale 1ns/100ps
module ssprb_top (
   input  wire logic       clk_i,
   input  wire logic       nrst_i,
   input  wire logic       sclk_i,
   input  wire logic       mosi_i,
   input  wire logic       port_select_n_i,
   input  wire logic       power_down_i,
   input  wire logic [7:0] motion_y_i,
   input  wire logic [7:0] motion_x_i,
   input  wire logic       motion_valid_i,
   input  wire logic [7:0] surface_quality_i,
   input  wire logic [7:0] exposure_hi_i,
   input  wire logic [7:0] exposure_lo_i,
   input  wire logic [7:0] peak_pixel_i,
   output logic            miso_o,
   output logic            miso_oe_o,
   output logic            motion_n_o,
   output logic            light_source_ctrl_o,
   output logic            forced_rest_o,
   output logic            port_ready_o
);
   // ------------------------------------------------------------
   // Reset release and input synchronisers
   // ------------------------------------------------------------
   logic [1:0] rst_sync_ff;
   logic       rst_n;
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_sync_ff <= 2'h0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_ff[1];

   logic [2:0] pd_sync_ff, sel_sync_ff, tgl_sync_ff;
   logic       pd_lvl_ff, sel_lvl_ff;
   ssprb_xfer_if xfer ();
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         pd_sync_ff  <= 3'h0;
         sel_sync_ff <= 3'h7;
         tgl_sync_ff <= 3'h0;
         pd_lvl_ff   <= 1'b0;
         sel_lvl_ff  <= 1'b1;
      end else begin
         pd_sync_ff  <= {pd_sync_ff[1:0], power_down_i};
         sel_sync_ff <= {sel_sync_ff[1:0], port_select_n_i};
         tgl_sync_ff <= {tgl_sync_ff[1:0], xfer.req_tgl};
         if (pd_sync_ff[1] == pd_sync_ff[2]) begin
            pd_lvl_ff <= pd_sync_ff[2];
         end
         if (sel_sync_ff[1] == sel_sync_ff[2]) begin
            sel_lvl_ff <= sel_sync_ff[2];
         end
      end
   end

   // ------------------------------------------------------------
   // Core register state
   // ------------------------------------------------------------
   logic       tgl_seen_ff, nxt_tgl_seen;
   logic       armed_ff, nxt_armed;
   logic       sel_prev_ff;
   logic [7:0] config_ff, nxt_config;
   logic [7:0] dy_ff, nxt_dy;
   logic [7:0] dx_ff, nxt_dx;
   logic       mot_ff, nxt_mot;
   logic       ovf_ff, nxt_ovf;
   logic [7:0] cap_ff [ssprb_pkg::BURST_LEN];
   logic [7:0] nxt_cap [ssprb_pkg::BURST_LEN];
   logic [7:0] status_byte;
   logic       req_evt;
   logic       mem_we;
   logic [7:0] mem_rdata;

   assign req_evt     = (tgl_sync_ff[2] != tgl_seen_ff);
   assign status_byte = {mot_ff, 2'h0, ovf_ff, 4'h0};

   always_comb begin
      nxt_tgl_seen = tgl_sync_ff[2];
      nxt_armed    = armed_ff;
      nxt_config   = config_ff;
      nxt_dy       = dy_ff;
      nxt_dx       = dx_ff;
      nxt_mot      = mot_ff;
      nxt_ovf      = ovf_ff;
      mem_we       = 1'b0;
      nxt_cap      = cap_ff;
      if (sel_prev_ff && !sel_lvl_ff) begin
         nxt_armed = 1'b1;
      end
      if (req_evt && xfer.req_wr) begin
         mem_we = 1'b1;
         unique case (xfer.req_addr)
            ssprb_pkg::ADDR_CONFIG_BITS: begin
               nxt_config = xfer.req_data;
            end
            ssprb_pkg::ADDR_MOVEMENT_STATUS: begin
               nxt_mot = 1'b0;
               nxt_ovf = 1'b0;
               nxt_dy  = 8'h00;
               nxt_dx  = 8'h00;
            end
            ssprb_pkg::ADDR_RESET_COMMAND: begin
               if (xfer.req_data == ssprb_pkg::RESET_KEY) begin
                  nxt_config = ssprb_pkg::CONFIG_BITS_RESET;
                  nxt_mot    = 1'b0;
                  nxt_ovf    = 1'b0;
                  nxt_dy     = 8'h00;
                  nxt_dx     = 8'h00;
               end
            end
            default: begin
            end
         endcase
      end else if (req_evt) begin
         // Taken before this cycle's clear; the link reads it after the host's gap
         nxt_cap[0] = (xfer.req_addr == ssprb_pkg::ADDR_MOVEMENT_STATUS) ? status_byte :
                      (xfer.req_addr == ssprb_pkg::ADDR_Y_DISPLACEMENT)  ? dy_ff :
                      (xfer.req_addr == ssprb_pkg::ADDR_X_DISPLACEMENT)  ? dx_ff :
                      (xfer.req_addr == ssprb_pkg::ADDR_CONFIG_BITS)     ? config_ff : mem_rdata;
         if (xfer.req_addr == ssprb_pkg::ADDR_BURST_READOUT) begin
            nxt_cap = '{status_byte, dy_ff, dx_ff, surface_quality_i, exposure_hi_i,
                        exposure_lo_i, peak_pixel_i};
         end
         if (xfer.req_addr == ssprb_pkg::ADDR_Y_DISPLACEMENT) begin
            nxt_dy = 8'h00;
         end
         if (xfer.req_addr == ssprb_pkg::ADDR_X_DISPLACEMENT ||
             xfer.req_addr == ssprb_pkg::ADDR_BURST_READOUT) begin
            nxt_dx  = 8'h00;
            nxt_dy  = 8'h00;
            nxt_mot = 1'b0;
         end
      end
      // New motion wins over a clear in the same cycle
      if (motion_valid_i) begin
         {nxt_ovf, nxt_dy} = {1'b0, nxt_dy} + {1'b0, motion_y_i};
         nxt_ovf = nxt_ovf | ovf_ff;
         nxt_dx  = nxt_dx + motion_x_i;
         nxt_mot = 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         tgl_seen_ff <= 1'b0;
         armed_ff    <= 1'b0;
         sel_prev_ff <= 1'b1;
         config_ff   <= ssprb_pkg::CONFIG_BITS_RESET;
         dy_ff       <= 8'h00;
         dx_ff       <= 8'h00;
         mot_ff      <= 1'b0;
         ovf_ff      <= 1'b0;
         cap_ff      <= '{default: 8'h00};
      end else begin
         tgl_seen_ff <= nxt_tgl_seen;
         armed_ff    <= nxt_armed;
         sel_prev_ff <= sel_lvl_ff;
         config_ff   <= nxt_config;
         dy_ff       <= nxt_dy;
         dx_ff       <= nxt_dx;
         mot_ff      <= nxt_mot;
         ovf_ff      <= nxt_ovf;
         cap_ff      <= nxt_cap;
      end
   end

   ssprb_regmem #(
      .DEPTH (ssprb_pkg::REG_DEPTH),
      .AW    (7)
   ) u_mem (
      .clk_i   (clk_i),
      .we_i    (mem_we),
      .waddr_i (xfer.req_addr),
      .wdata_i (xfer.req_data),
      .raddr_i (xfer.req_addr),
      .rdata_o (mem_rdata)
   );

   assign motion_n_o          = ~mot_ff;
   assign light_source_ctrl_o = ~pd_lvl_ff;
   assign forced_rest_o       = config_ff[ssprb_pkg::CONFIG_REST_BIT];
   assign port_ready_o        = armed_ff & ~pd_lvl_ff;

   // ------------------------------------------------------------
   // Link domain on the serial clock
   // ------------------------------------------------------------
   typedef enum logic [1:0] {ADDR, RDATA, WDATA, LOCKED} ssprb_phase_e;
   ssprb_phase_e phase_ff, nxt_phase;
   logic [2:0]   bit_ff, nxt_bit;
   logic [6:0]   sh_ff, nxt_sh;
   logic [6:0]   addr_ff, nxt_addr;
   logic [2:0]   bidx_ff, nxt_bidx;
   logic         burst_ff, nxt_burst;
   logic         tgl_ff, nxt_tgl;
   logic         wr_ff, nxt_wr;
   logic [7:0]   wdata_ff, nxt_wdata;
   logic [7:0]   cur_byte;
   logic         link_rst_n;

   // Deselect or core reset clears the port at once, ending a burst
   assign link_rst_n = rst_n & ~port_select_n_i;

   always_comb begin
      nxt_phase = phase_ff;
      nxt_bit   = bit_ff + 3'h1;
      nxt_sh    = {sh_ff[5:0], mosi_i};
      nxt_addr  = addr_ff;
      nxt_bidx  = bidx_ff;
      nxt_burst = burst_ff;
      nxt_tgl   = tgl_ff;
      nxt_wr    = wr_ff;
      nxt_wdata = wdata_ff;
      unique case (phase_ff)
         ADDR: begin
            if (bit_ff == 3'h7) begin
               nxt_addr = {sh_ff[5:0], mosi_i};
               if (sh_ff[6]) begin
                  nxt_phase = WDATA;
               end else begin
                  nxt_phase = RDATA;
                  nxt_tgl   = ~tgl_ff;
                  nxt_wr    = 1'b0;
                  nxt_burst = ({sh_ff[5:0], mosi_i} == ssprb_pkg::ADDR_BURST_READOUT);
                  nxt_bidx  = 3'h0;
               end
            end
         end
         RDATA: begin
            if (bit_ff == 3'h7) begin
               if (burst_ff && bidx_ff != 3'(ssprb_pkg::BURST_LEN - 1)) begin
                  nxt_bidx = bidx_ff + 3'h1;
               end else begin
                  nxt_phase = LOCKED;
               end
            end
         end
         WDATA: begin
            if (bit_ff == 3'h7) begin
               nxt_wdata = {sh_ff, mosi_i};
               nxt_wr    = 1'b1;
               nxt_tgl   = ~tgl_ff;
               nxt_phase = ADDR;
            end
         end
         LOCKED: begin
            nxt_bit = bit_ff;
         end
      endcase
   end

   // Sample on rising edge
   always_ff @(posedge sclk_i or negedge link_rst_n) begin
      if (!link_rst_n) begin
         phase_ff <= ADDR;
         bit_ff   <= 3'h0;
         sh_ff    <= 7'h00;
         addr_ff  <= 7'h00;
         bidx_ff  <= 3'h0;
         burst_ff <= 1'b0;
         wr_ff    <= 1'b0;
         wdata_ff <= 8'h00;
      end else begin
         phase_ff <= nxt_phase;
         bit_ff   <= nxt_bit;
         sh_ff    <= nxt_sh;
         addr_ff  <= nxt_addr;
         bidx_ff  <= nxt_bidx;
         burst_ff <= nxt_burst;
         wr_ff    <= nxt_wr;
         wdata_ff <= nxt_wdata;
      end
   end

   // Toggle survives deselect so the core never sees a false event
   always_ff @(posedge sclk_i or negedge rst_n) begin
      if (!rst_n) begin
         tgl_ff <= 1'b0;
      end else if (!port_select_n_i) begin
         tgl_ff <= nxt_tgl;
      end
   end

   assign xfer.req_tgl  = tgl_ff;
   assign xfer.req_wr   = wr_ff;
   assign xfer.req_addr = addr_ff;
   assign xfer.req_data = wdata_ff;

   // Core capture stands still from address end until select rises, so no resync
   assign cur_byte = cap_ff[bidx_ff];

   // Output bit changes only on falling edge, or clears at once on deselect or core reset
   logic miso_ff;
   always_ff @(negedge sclk_i or negedge link_rst_n) begin
      if (!link_rst_n) begin
         miso_ff <= 1'b0;
      end else begin
         miso_ff <= (phase_ff == RDATA) ? cur_byte[3'h7 - bit_ff] : 1'b0;
      end
   end

   assign miso_o    = miso_ff;
   assign miso_oe_o = ~port_select_n_i & armed_ff & (phase_ff == RDATA);
endmodule

//--- verification/ssprb_top_props.sv
// Checker of the sensor port pins, sampled on the core clock.
// Assumes it is bound onto ssprb_top and sees only its ports.
`timescale 1ns/100ps
module ssprb_top_props (
   input  wire logic clk_i,
   input  wire logic nrst_i,
   input  wire logic sclk_i,
   input  wire logic port_select_n_i,
   input  wire logic power_down_i,
   input  wire logic miso_o,
   input  wire logic miso_oe_o,
   input  wire logic light_source_ctrl_o,
   input  wire logic forced_rest_o,
   input  wire logic port_ready_o
);
   // ------------------------------------------------------------
   // Pin relations
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   oe_release_a: assert property (port_select_n_i |-> !miso_oe_o)
      else $error("output driven while deselected");
   miso_hold_a: assert property (sclk_i && $past(sclk_i) && !port_select_n_i
      && $past(!port_select_n_i) && miso_oe_o |-> $stable(miso_o))
      else $error("output bit moved while serial clock high");
   dark_shutdown_a: assert property (power_down_i [*8] |-> !light_source_ctrl_o)
      else $error("light source not low in shutdown");
   lit_awake_a: assert property ((!power_down_i) [*8] |-> light_source_ctrl_o)
      else $error("light source low while awake");
   armed_only_a: assert property (!port_ready_o && !power_down_i |-> !miso_oe_o)
      else $error("output driven before port armed");
   ready_arm_a: assert property ($fell(port_select_n_i) && !power_down_i
      && light_source_ctrl_o |-> ##[1:8] port_ready_o)
      else $error("select edge did not arm port");
   // Writes land a few cycles after the last rising edge, still inside the frame
   rest_write_a: assert property ($changed(forced_rest_o) |-> sclk_i && !port_select_n_i)
      else $error("rest output changed outside a write");
   oe_frame_a: assert property ($rose(miso_oe_o) |-> $past(!port_select_n_i, 8))
      else $error("output started without address phase");
   cover property ($rose(miso_oe_o));
   cover property ($rose(forced_rest_o));
   cover property ($fell(light_source_ctrl_o));
endmodule
bind ssprb_top ssprb_top_props u_props (.clk_i(clk_i), .nrst_i(nrst_i), .sclk_i(sclk_i),
   .port_select_n_i(port_select_n_i), .power_down_i(power_down_i), .miso_o(miso_o),
   .miso_oe_o(miso_oe_o), .light_source_ctrl_o(light_source_ctrl_o),
   .forced_rest_o(forced_rest_o), .port_ready_o(port_ready_o));

//--- verification/ssprb_host_model.sv
// Host model: master of the four-wire sensor port, clock idle high.
// Assumes one bench process calls its tasks; clock stands still between frames.
`timescale 1ns/100ps
module ssprb_host_model (
   input  wire logic clk_i,
   input  wire logic miso_i,
   input  wire logic miso_oe_i,
   output logic      sclk_o,
   output logic      mosi_o,
   output logic      port_select_n_o
);
   // ------------------------------------------------------------
   // Serial master
   // ------------------------------------------------------------
   logic fill = 1'b0;
   wire  miso_w = miso_oe_i ? miso_i : fill; // Released line never shows a stale bit
   initial begin
      sclk_o = 1'b1;
      mosi_o = 1'b0;
      port_select_n_o = 1'b1;
   end
   always @(negedge sclk_o) fill <= ~fill;
   task automatic sync();
      @(posedge clk_i);
      #1.3; // Keeps serial edges off the core clock edge
   endtask
   task automatic frame_begin(); // Select high then low arms the port
      sync();
      port_select_n_o = 1'b0;
      #80;
   endtask
   task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         sclk_o = 1'b0;
         mosi_o = tx[i];
         #80;
         sclk_o = 1'b1;
         rx[i] = miso_w;
         #80;
      end
   endtask
   task automatic gap(); // Clock held off before data
      sync();
      #400;
   endtask
   task automatic frame_end();
      port_select_n_o = 1'b1;
      mosi_o = ~mosi_o;
      #400;
   endtask
endmodule

//--- verification/ssprb_top_tb.sv
// Bench of the sensor port: registers, burst, abort and shutdown.
// Assumes the host model drives the serial pins, the bench the core inputs.
`timescale 1ns/100ps
module ssprb_top_tb;
   // ------------------------------------------------------------
   // Set-up
   // ------------------------------------------------------------
   localparam int power_down_pulse_min = 40; // Shortened, in core cycles
   logic       clk_i = 1'b0;
   logic       nrst_i = 1'b0;
   logic       pd = 1'b0; // Low until reset done
   logic       mv = 1'b0;
   logic [7:0] my = 8'h00;
   logic [7:0] mx = 8'h00;
   logic [7:0] sq = 8'h41;
   logic [7:0] eh = 8'h52;
   logic [7:0] el = 8'h63;
   logic [7:0] pk = 8'h74;
   wire        sclk, mosi, sel_n, miso, oe, mot_n, light, rest, ready;
   int         mismatches = 0;
   int         comparisons = 0;
   int         cycles = 0;
   int         hits = 0;
   ssprb_top dut (.clk_i(clk_i), .nrst_i(nrst_i), .sclk_i(sclk), .mosi_i(mosi),
      .port_select_n_i(sel_n), .power_down_i(pd), .motion_y_i(my), .motion_x_i(mx),
      .motion_valid_i(mv), .surface_quality_i(sq), .exposure_hi_i(eh), .exposure_lo_i(el),
      .peak_pixel_i(pk), .miso_o(miso), .miso_oe_o(oe), .motion_n_o(mot_n),
      .light_source_ctrl_o(light), .forced_rest_o(rest), .port_ready_o(ready));
   ssprb_host_model host (.clk_i(clk_i), .miso_i(miso), .miso_oe_i(oe), .sclk_o(sclk),
      .mosi_o(mosi), .port_select_n_o(sel_n));
   initial forever #2 clk_i = ~clk_i;
   always @(posedge sclk) if (oe) hits++;
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 60000) begin
         mismatches++;
         $display("[ERR] %0t run hung", $time);
         results();
      end
   end
   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] r;
      host.frame_begin();
      host.xbyte({1'b1, a}, r);
      host.xbyte(d, r);
      host.frame_end();
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] e, input string what);
      logic [7:0] r;
      host.frame_begin();
      host.xbyte({1'b0, a}, r);
      host.gap();
      host.xbyte(8'h00, r);
      host.frame_end();
      check(r, e, what);
   endtask
   task automatic move(input logic [7:0] y, input logic [7:0] x);
      @(posedge clk_i);
      my <= y;
      mx <= x;
      mv <= 1'b1;
      @(posedge clk_i);
      mv <= 1'b0;
      repeat (8) @(posedge clk_i);
   endtask
   task automatic burst(input int n, input logic [7:0] y, input logic [7:0] x);
      logic [7:0] r;
      logic [7:0] e [7];
      int         h;
      e = '{8'h80, y, x, sq, eh, el, pk};
      host.frame_begin();
      host.xbyte({1'b0, ssprb_pkg::ADDR_BURST_READOUT}, r);
      @(posedge clk_i);
      sq <= ~sq; // Late change must miss the captured bytes
      host.gap();
      for (int i = 0; i < n; i++) begin
         host.xbyte(8'h00, r);
         check(r, e[i], "burst byte");
      end
      if (n == 7) begin
         h = hits;
         host.xbyte({1'b0, ssprb_pkg::ADDR_CONFIG_BITS}, r);
         host.gap();
         host.xbyte(8'h00, r);
         check(8'(hits - h), 8'h00, "answer after burst");
      end
      host.frame_end();
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial begin
      logic [7:0] r;
      repeat (6) @(posedge clk_i);
      nrst_i <= 1'b1;
      repeat (10) @(posedge clk_i);
      wr(ssprb_pkg::ADDR_RESET_COMMAND, ssprb_pkg::RESET_KEY);
      rd(ssprb_pkg::ADDR_CONFIG_BITS, ssprb_pkg::CONFIG_BITS_RESET, "cfg");
      move(8'h05, 8'hfd);
      check({7'h00, mot_n}, 8'h00, "motion set");
      rd(ssprb_pkg::ADDR_MOVEMENT_STATUS, 8'h80, "status");
      rd(ssprb_pkg::ADDR_Y_DISPLACEMENT, 8'h05, "y");
      rd(ssprb_pkg::ADDR_X_DISPLACEMENT, 8'hfd, "x");
      check({7'h00, mot_n}, 8'h01, "motion clear");
      wr(ssprb_pkg::ADDR_CONFIG_BITS, 8'h23);
      check({7'h00, rest}, 8'h01, "rest on");
      host.frame_begin();
      host.xbyte({1'b1, ssprb_pkg::ADDR_CONFIG_BITS}, r);
      host.frame_end();
      rd(ssprb_pkg::ADDR_CONFIG_BITS, 8'h23, "cfg after abort");
      wr(ssprb_pkg::ADDR_CONFIG_BITS, 8'h03);
      check({7'h00, rest}, 8'h00, "rest off");
      move(8'h12, 8'h34);
      burst(7, 8'h12, 8'h34);
      check({7'h00, mot_n}, 8'h01, "burst clear");
      move(8'h01, 8'h02);
      burst(3, 8'h01, 8'h02);
      rd(ssprb_pkg::ADDR_CONFIG_BITS, 8'h03, "cfg after early end");
      move(8'h07, 8'h07);
      wr(ssprb_pkg::ADDR_MOVEMENT_STATUS, 8'hff);
      rd(ssprb_pkg::ADDR_MOVEMENT_STATUS, 8'h00, "status cleared");
      wr(ssprb_pkg::ADDR_CONFIG_BITS, 8'h23);
      @(posedge clk_i);
      pd <= 1'b1; // Select held high meanwhile
      repeat (power_down_pulse_min) @(posedge clk_i);
      @(negedge clk_i);
      check({7'h00, light}, 8'h00, "light in shutdown");
      check({7'h00, ready}, 8'h00, "ready in shutdown");
      @(posedge clk_i);
      pd <= 1'b0;
      repeat (power_down_pulse_min) @(posedge clk_i);
      wr(ssprb_pkg::ADDR_RESET_COMMAND, ssprb_pkg::RESET_KEY);
      rd(ssprb_pkg::ADDR_CONFIG_BITS, ssprb_pkg::CONFIG_BITS_RESET, "cfg wake");
      check({7'h00, ready}, 8'h01, "ready after wake");
      results();
   end
endmodule
